/* File: logic/gicl_pkg.sv */
// Constants, encodings and types shared by the gauge interface command link.
package gicl_pkg;
   // =========================================================================
   // =========================================================================

   // =========================================================================
   // Timing
   // =========================================================================
   localparam int unsigned CLK_HZ = 10_000_000; // System clock rate in hertz.
   localparam int unsigned BAUD_RATE = 9600; // Serial rate in bits per second.
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE; // Bit period, rounded down.
   localparam int unsigned CNT_W = $clog2(BIT_CYCLES + 1); // Width of the bit timers.
   localparam logic [CNT_W-1:0] BIT_LOAD = CNT_W'(BIT_CYCLES - 1); // Timer load for one bit.
   localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(BIT_CYCLES / 2 - 1); // Timer load to mid start bit.
   localparam logic [3:0] DATA_BITS = 4'h8; // Data bits per character.
   localparam logic [3:0] FRAME_LAST = 4'h9; // Index of the single stop bit in a frame.
   localparam logic TX_IDLE_LEVEL = 1'b1; // Line level between frames.

   // =========================================================================
   // Sizes and reset values
   // =========================================================================
   localparam int unsigned FIFO_DEPTH = 16; // Characters buffered ahead of the transmitter.
   localparam int unsigned LINE_CHARS = 16; // Longest single command kept.
   localparam logic [3:0] RESP_LAST = 4'h2; // Last index of a response: code, code, CR.
   localparam logic [3:0] DATA_FIRST = 4'h4; // First index of the value body.
   localparam logic [3:0] DATA_LAST = 4'hC; // Last index of a data string, the CR.
   localparam logic [3:0] BODY_LAST = 4'h7; // Last position of the eight character body.
   localparam logic [1:0] REQ_EN_RESET = 2'b11; // Software requests enabled after reset.
   localparam logic [1:0] KEY_EN_RESET = 2'b11; // Gauge data keys enabled after reset.
   localparam logic [1:0] PERM_EN_RESET = 2'b00; // Streaming off after reset.

   // =========================================================================
   // Characters
   // =========================================================================
   localparam logic [7:0] NUL = 8'h00;
   localparam logic [7:0] CR = 8'h0D;
   localparam logic [7:0] SPACE = 8'h20;
   localparam logic [7:0] PLUS = 8'h2B;
   localparam logic [7:0] COMMA = 8'h2C;
   localparam logic [7:0] MINUS = 8'h2D;
   localparam logic [7:0] DOT = 8'h2E;
   localparam logic [7:0] ZERO = 8'h30;
   localparam logic [7:0] ONE = 8'h31;
   localparam logic [7:0] TWO = 8'h32;
   localparam logic [7:0] NINE = 8'h39;
   localparam logic [7:0] COLON = 8'h3A;
   localparam logic [7:0] LET_C = 8'h43;
   localparam logic [7:0] LET_E = 8'h45;
   localparam logic [7:0] LET_K = 8'h4B;
   localparam logic [7:0] LET_O = 8'h4F;
   localparam logic [23:0] NAME_DAD = 24'h444144;
   localparam logic [23:0] NAME_DAE = 24'h444145;
   localparam logic [23:0] NAME_DAG = 24'h444147;
   localparam logic [23:0] NAME_DAS = 24'h444153;
   localparam logic [23:0] NAME_DAP = 24'h444150;
   localparam logic [23:0] NAME_PSP = 24'h505350;
   localparam logic [23:0] NAME_IOC = 24'h494F43;
   localparam logic [39:0] NAME_RESET = 40'h5245534554;
   localparam logic [15:0] WORD_ON = 16'h4F4E;
   localparam logic [23:0] WORD_OFF = 24'h4F4646;

   // =========================================================================
   // Answer codes: the digit sent after the error letter, zero for success
   // =========================================================================
   localparam logic [7:0] CODE_OK = 8'h00;
   localparam logic [7:0] syntax_error_code = 8'h31;
   localparam logic [7:0] bad_terminator_code = 8'h32;
   localparam logic [7:0] bad_numeric_code = 8'h33;
   localparam logic [7:0] channel_low_code = 8'h34;
   localparam logic [7:0] channel_high_code = 8'h35;
   localparam logic [7:0] onoff_unrecognized_code = 8'h36;
   localparam logic [7:0] comma_missing_code = 8'h37;
   localparam logic [7:0] undefined_option_code = 8'h38;

   // =========================================================================
   // Types
   // =========================================================================
   typedef enum logic [3:0] {
      CMD_NONE, CMD_DIS, CMD_ENA, CMD_KEY, CMD_REQ, CMD_PERM, CMD_IDENT, CMD_MODULES, CMD_RESET
   } gicl_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESP = 2'b01,
      ST_DATA = 2'b11
   } gicl_phase_t;

   typedef struct packed {
      logic [7:0] err; // Answer code.
      gicl_cmd_t cmd; // Decoded command.
      logic [1:0] chm; // Channels addressed.
      logic on; // ON word seen.
   } gicl_result_t;
endpackage

/* File: logic/gicl_fifo.sv */
// Character FIFO with a registered output stage between responder and transmitter.
`timescale 1ns/1ns
module gicl_fifo import gicl_pkg::*; #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int unsigned PW = $clog2(DEPTH); // Pointer width, DEPTH a power of two.
   localparam int unsigned CW = $clog2(DEPTH + 1); // Count width.

   // All state of the FIFO.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage.
      logic [PW-1:0] wp; // Write pointer.
      logic [PW-1:0] rp; // Read pointer.
      logic [CW-1:0] cnt; // Words held in storage.
      logic ov; // Output stage holds a word.
      logic [WIDTH-1:0] od; // Output stage word.
      logic ir; // Storage has room.
   } gicl_fifo_state_t;

   gicl_fifo_state_t r;
   gicl_fifo_state_t next_r;
   logic push;
   logic pop;

   // =========================================================================
   // Next state: the output stage refills from storage as soon as it frees.
   // =========================================================================
   always_comb begin
      next_r = r;
      push = in_valid_in && r.ir;
      pop = (r.cnt != '0) && (!r.ov || out_ready_in);
      if (r.ov && out_ready_in) begin
         next_r.ov = 1'b0;
      end
      if (pop) begin
         next_r.od = r.mem[r.rp];
         next_r.ov = 1'b1;
         next_r.rp = r.rp + 1'b1;
      end
      if (push) begin
         next_r.mem[r.wp] = in_data_in;
         next_r.wp = r.wp + 1'b1;
      end
      next_r.cnt = r.cnt + CW'(push) - CW'(pop);
      // Ready is registered, so it looks at the count after this cycle.
      next_r.ir = next_r.cnt < CW'(DEPTH);
   end

   // Registers of the FIFO, synchronous reset.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign in_ready_out = r.ir;
   assign out_valid_out = r.ov;
   assign out_data_out = r.od;
endmodule // gicl_fifo

/* File: logic/gicl_command_link.sv */
// Serial command interpreter: receiver, line parser, responder and transmitter.
`timescale 1ns/1ns
module gicl_command_link import gicl_pkg::*; #(
   parameter int unsigned TX_FIFO_DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic rx_in,
   input wire logic [1:0] meas_neg_in,
   input wire logic [55:0] meas_bcd_in,
   input wire logic [5:0] meas_point_in,
   input wire logic [1:0] meas_key_in,
   output logic tx_out,
   output logic busy_out,
   output logic rx_overrun_out,
   output logic [1:0] req_enable_out,
   output logic [1:0] key_enable_out,
   output logic [1:0] perm_enable_out
);
   // =========================================================================
   // State
   // =========================================================================
   typedef struct packed {
      logic [CNT_W-1:0] rx_cnt; // Receive bit timer.
      logic [3:0] rx_bit; // Receive bit index, 0 is start.
      logic [7:0] rx_sh; // Receive shifter, LSB first.
      logic rx_busy; // Inside a received frame.
      logic [LINE_CHARS-1:0][7:0] buff; // Current command, first char at 0.
      logic [4:0] len; // Characters in the buffer.
      logic ovf; // Command too long.
      logic bad_term; // Stray control character seen.
      gicl_phase_t ph; // Responder phase.
      gicl_result_t res; // Result being answered.
      logic [3:0] idx; // Character index within a message.
      logic ch; // Channel being sent.
      logic [1:0] mask; // Channels still to send.
      logic [1:0] key_pend; // Data key presses waiting.
      logic lneg; // Latched sign.
      logic [27:0] lbcd; // Latched digits.
      logic [2:0] lpt; // Latched decimals.
      logic [1:0] req_en; // Measurement requests allowed.
      logic [1:0] key_en; // Data key allowed.
      logic [1:0] perm_en; // Streaming on.
      logic [CNT_W-1:0] tx_cnt; // Transmit bit timer.
      logic [3:0] tx_bit; // Transmit bit index.
      logic [9:0] tx_sh; // Transmit frame, start bit at 0.
      logic tx_busy; // Transmitter sending.
      logic tx_line; // Serial output level.
      logic busy; // Responder not idle.
      logic overrun; // Character dropped while busy.
   } gicl_state_t;

   gicl_state_t r;
   gicl_state_t next_r;
   logic rx_done; // A whole character with a good stop bit arrived.
   logic push; // Responder offers a character.
   logic [7:0] ch_out; // Character offered.
   logic fifo_ready;
   logic fifo_valid;
   logic [7:0] fifo_data;
   gicl_result_t pr;
   logic [1:0] trig;

   // =========================================================================
   // Command decoder. The buffer holds zeros past the last character.
   // =========================================================================
   function automatic gicl_result_t parse_cmd(input logic [LINE_CHARS-1:0][7:0] b);
      gicl_result_t q;
      logic [3:0] p;
      q = '0;
      q.cmd = CMD_NONE;
      q.chm = 2'b11;
      p = 4'h3;
      if ({b[0], b[1], b[2], b[3], b[4]} == NAME_RESET) begin
         q.cmd = CMD_RESET;
         p = 4'h5;
      end else begin
         case ({b[0], b[1], b[2]})
            NAME_DAD: q.cmd = CMD_DIS;
            NAME_DAE: q.cmd = CMD_ENA;
            NAME_DAG: q.cmd = CMD_KEY;
            NAME_DAS: q.cmd = CMD_REQ;
            NAME_DAP: q.cmd = CMD_PERM;
            NAME_PSP: q.cmd = CMD_IDENT;
            NAME_IOC: q.cmd = CMD_MODULES;
            default: q.err = syntax_error_code;
         endcase
      end
      // Optional channel with optional sub-channel for the data commands.
      if (q.err == CODE_OK && q.cmd inside {CMD_DIS, CMD_ENA, CMD_KEY, CMD_REQ, CMD_PERM}) begin
         if (b[p] == SPACE) begin
            p = p + 4'h1;
         end
         if (b[p] >= ZERO && b[p] <= NINE) begin
            if (b[p] == ZERO) begin
               q.err = channel_low_code;
            end else if (b[p] > TWO) begin
               q.err = channel_high_code;
            end else begin
               q.chm = (b[p] == ONE) ? 2'b01 : 2'b10;
               p = p + 4'h1;
               if (b[p] == DOT) begin
                  p = p + 4'h1;
                  if (b[p] == ONE || b[p] == TWO) begin
                     p = p + 4'h1;
                  end else begin
                     q.err = bad_numeric_code;
                  end
               end
            end
         end else if (b[p] != NUL && b[p] != COMMA) begin
            q.err = bad_numeric_code;
         end
      end
      // The switching commands need a comma and an ON or OFF word.
      if (q.err == CODE_OK && q.cmd inside {CMD_KEY, CMD_PERM}) begin
         if (b[p] != COMMA) begin
            q.err = comma_missing_code;
         end else if ({b[p+4'h1], b[p+4'h2], b[p+4'h3]} == WORD_OFF) begin
            p = p + 4'h4;
         end else if ({b[p+4'h1], b[p+4'h2]} == WORD_ON) begin
            q.on = 1'b1;
            p = p + 4'h3;
         end else begin
            q.err = onoff_unrecognized_code;
         end
      end
      if (q.err == CODE_OK && b[p] != NUL) begin
         q.err = undefined_option_code;
      end
      return q;
   endfunction

   // Character k of the eight character body: seven digits and a point, leading zeros kept.
   function automatic logic [7:0] body_char(input logic [3:0] k, input logic [27:0] bcd, input logic [2:0] pt);
      logic [3:0] dot;
      logic [3:0] j;
      logic [7:0] c;
      dot = BODY_LAST - {1'b0, pt};
      j = (k < dot) ? k : k - 4'h1;
      c = ZERO | {4'h0, bcd[27 - 4 * int'(j) -: 4]};
      if (k == dot) begin
         c = DOT;
      end
      return c;
   endfunction

   // =========================================================================
   // Next state.
   // =========================================================================
   always_comb begin
      next_r = r;
      rx_done = 1'b0;
      push = 1'b0;
      ch_out = NUL;
      pr = '0;
      trig = (r.key_pend | r.perm_en) & r.req_en;

      // Receiver: 8 data bits, LSB first, one stop bit, sampled mid bit.
      if (!r.rx_busy) begin
         if (!rx_in) begin
            next_r.rx_busy = 1'b1;
            next_r.rx_cnt = HALF_LOAD;
            next_r.rx_bit = 4'h0;
         end
      end else if (r.rx_cnt != '0) begin
         next_r.rx_cnt = r.rx_cnt - 1'b1;
      end else begin
         next_r.rx_cnt = BIT_LOAD;
         next_r.rx_bit = r.rx_bit + 4'h1;
         if (r.rx_bit == 4'h0) begin
            // A start bit that went high again was a glitch.
            next_r.rx_busy = !rx_in;
         end else if (r.rx_bit <= DATA_BITS) begin
            next_r.rx_sh = {rx_in, r.rx_sh[7:1]};
         end else begin
            // Framing errors drop the character silently.
            next_r.rx_busy = 1'b0;
            rx_done = rx_in;
         end
      end

      // Key presses wait until served; a new press beats the clearing below.
      next_r.key_pend = r.key_pend | (meas_key_in & r.key_en);

      // Line assembly and command execution, one command at a time.
      if (rx_done) begin
         if (r.ph != ST_IDLE) begin
            // Characters arriving while answering are lost and flagged.
            next_r.overrun = 1'b1;
         end else if (r.rx_sh == COLON || r.rx_sh == CR) begin
            pr = parse_cmd(r.buff);
            if (r.ovf) begin
               pr.err = syntax_error_code;
            end else if (r.bad_term && pr.err == CODE_OK) begin
               pr.err = bad_terminator_code;
            end
            next_r.res = pr;
            next_r.buff = '0;
            next_r.len = 5'h00;
            next_r.ovf = 1'b0;
            next_r.bad_term = 1'b0;
            next_r.mask = 2'b00;
            // An empty command between separators gets no answer.
            if (r.len != 5'h00 || r.ovf) begin
               next_r.ph = ST_RESP;
               next_r.idx = 4'h0;
            end
            // Commands failing with any code but bad_terminator_code change nothing.
            if (r.len != 5'h00 && (pr.err == CODE_OK || pr.err == bad_terminator_code)) begin
               case (pr.cmd)
                  CMD_DIS: next_r.req_en = r.req_en & ~pr.chm;
                  CMD_ENA: next_r.req_en = r.req_en | pr.chm;
                  CMD_KEY: next_r.key_en = pr.on ? (r.key_en | pr.chm) : (r.key_en & ~pr.chm);
                  CMD_PERM: next_r.perm_en = pr.on ? (r.perm_en | pr.chm) : (r.perm_en & ~pr.chm);
                  CMD_REQ: next_r.mask = pr.chm & r.req_en;
                  CMD_RESET: begin
                     next_r.req_en = REQ_EN_RESET;
                     next_r.key_en = KEY_EN_RESET;
                     next_r.perm_en = PERM_EN_RESET;
                     // A key press in the same cycle as the reset command still counts.
                     next_r.key_pend = meas_key_in & KEY_EN_RESET;
                  end
                  default: ;
               endcase
            end
         end else if (r.rx_sh < SPACE) begin
            next_r.bad_term = 1'b1;
         end else if (r.len == 5'(LINE_CHARS)) begin
            next_r.ovf = 1'b1;
         end else begin
            next_r.buff[r.len[3:0]] = r.rx_sh;
            next_r.len = r.len + 5'h01;
         end
      end else if (r.ph == ST_IDLE && !r.rx_busy && r.len == 5'h00 && trig != 2'b00) begin
         // Key or streaming sends only between lines so commands are not starved.
         next_r.mask = trig;
         next_r.key_pend = meas_key_in & r.key_en;
         next_r.ch = !trig[0];
         next_r.idx = 4'h0;
         next_r.ph = ST_DATA;
      end

      // Responder: one character per cycle while the FIFO has room.
      case (r.ph)
         ST_IDLE: ;
         ST_RESP: begin
            push = 1'b1;
            if (r.idx == 4'h0) begin
               ch_out = (r.res.err == CODE_OK) ? LET_O : LET_E;
            end else if (r.idx == 4'h1) begin
               ch_out = (r.res.err == CODE_OK) ? LET_K : r.res.err;
            end else begin
               ch_out = CR;
            end
            if (fifo_ready) begin
               next_r.idx = r.idx + 4'h1;
               if (r.idx == RESP_LAST) begin
                  next_r.idx = 4'h0;
                  next_r.ch = !r.mask[0];
                  next_r.ph = (r.mask != 2'b00) ? ST_DATA : ST_IDLE;
               end
            end
         end
         ST_DATA: begin
            push = 1'b1;
            case (r.idx)
               4'h0: begin
                  ch_out = LET_C;
                  // Freeze the value so a string never mixes two readings.
                  next_r.lneg = meas_neg_in[r.ch];
                  next_r.lbcd = r.ch ? meas_bcd_in[55:28] : meas_bcd_in[27:0];
                  next_r.lpt = r.ch ? meas_point_in[5:3] : meas_point_in[2:0];
               end
               4'h1: ch_out = r.ch ? TWO : ONE;
               4'h2: ch_out = ZERO;
               4'h3: ch_out = r.lneg ? MINUS : PLUS;
               DATA_LAST: ch_out = CR;
               default: ch_out = body_char(r.idx - DATA_FIRST, r.lbcd, r.lpt);
            endcase
            if (fifo_ready) begin
               next_r.idx = r.idx + 4'h1;
               if (r.idx == DATA_LAST) begin
                  next_r.idx = 4'h0;
                  next_r.mask[r.ch] = 1'b0;
                  next_r.ch = !r.ch;
                  if (r.mask[!r.ch] == 1'b0) begin
                     next_r.ph = ST_IDLE;
                  end
               end
            end
         end
         default: next_r.ph = ST_IDLE;
      endcase
      next_r.busy = next_r.ph != ST_IDLE;

      // Transmitter: start bit, 8 data bits LSB first, one stop bit.
      if (!r.tx_busy) begin
         if (fifo_valid) begin
            next_r.tx_sh = {1'b1, fifo_data, 1'b0};
            next_r.tx_busy = 1'b1;
            next_r.tx_bit = 4'h0;
            next_r.tx_cnt = BIT_LOAD;
            next_r.tx_line = 1'b0;
         end
      end else if (r.tx_cnt != '0) begin
         next_r.tx_cnt = r.tx_cnt - 1'b1;
      end else if (r.tx_bit == FRAME_LAST) begin
         next_r.tx_busy = 1'b0;
         next_r.tx_line = TX_IDLE_LEVEL;
      end else begin
         next_r.tx_bit = r.tx_bit + 4'h1;
         next_r.tx_line = r.tx_sh[r.tx_bit + 4'h1];
         next_r.tx_cnt = BIT_LOAD;
      end
   end

   // =========================================================================
   // Registers, synchronous active low reset.
   // =========================================================================
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         r <= '0;
         r.tx_line <= TX_IDLE_LEVEL;
         r.req_en <= REQ_EN_RESET;
         r.key_en <= KEY_EN_RESET;
         r.perm_en <= PERM_EN_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Characters queue here so the responder waits on the slow line only once the FIFO is full.
   gicl_fifo #(
      .WIDTH(8),
      .DEPTH(TX_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .in_valid_in(push),
      .in_data_in(ch_out),
      .in_ready_out(fifo_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(!r.tx_busy)
   );

   assign tx_out = r.tx_line;
   assign busy_out = r.busy;
   assign rx_overrun_out = r.overrun;
   assign req_enable_out = r.req_en;
   assign key_enable_out = r.key_en;
   assign perm_enable_out = r.perm_en;
endmodule // gicl_command_link

/* File: dv/gicl_command_link_sva.sv */
// Port checker for the command link.
`timescale 1ns/1ns
module gicl_command_link_sva import gicl_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic rx_in,
   input wire logic tx_out,
   input wire logic busy_out,
   input wire logic rx_overrun_out,
   input wire logic [1:0] req_enable_out,
   input wire logic [1:0] key_enable_out,
   input wire logic [1:0] perm_enable_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic [CNT_W-1:0] run; // Cycles since tx_out moved; saturates so long idle never wraps.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) run <= '1;
      else if ($changed(tx_out)) run <= CNT_W'(1);
      else if (run != '1) run <= run + 1'b1;
   end
   property p_idle; disable iff (1'b0) !resetn_in |=> tx_out && !busy_out && !rx_overrun_out; endproperty
   a_idle: assert property (p_idle) else $error("line not idle in reset");
   property p_rst; disable iff (1'b0) !resetn_in |=>
      {req_enable_out, key_enable_out, perm_enable_out} == {REQ_EN_RESET, KEY_EN_RESET, PERM_EN_RESET}; endproperty
   a_rst: assert property (p_rst) else $error("enables wrong in reset");
   property p_bit; $changed(tx_out) |-> run >= BIT_CYCLES; endproperty
   a_bit: assert property (p_bit) else $error("serial bit too short");
   property p_busy; $rose(busy_out) |-> $past(rx_in); endproperty
   a_busy: assert property (p_busy) else $error("answer without stop bit");
   // With the transmitter idle, an answer must reach the line within a few clocks.
   property p_start; $rose(busy_out) && tx_out && run > BIT_CYCLES + 2 |-> ##[1:8] !tx_out; endproperty
   a_start: assert property (p_start) else $error("answer not started");
   property p_keep; rx_overrun_out |=> rx_overrun_out; endproperty
   a_keep: assert property (p_keep) else $error("overrun flag lost");
   property p_ovr; $rose(rx_overrun_out) |-> $past(busy_out) || $past(busy_out, 2); endproperty
   a_ovr: assert property (p_ovr) else $error("overrun while idle");
   property p_en; $changed({req_enable_out, key_enable_out, perm_enable_out}) |-> ##[0:2] busy_out; endproperty
   a_en: assert property (p_en) else $error("enable moved without answer");
   c_busy: cover property ($rose(busy_out));
   c_frame: cover property ($fell(tx_out) ##1 !tx_out);
   c_done: cover property (busy_out ##1 !busy_out);
endmodule // gicl_command_link_sva
bind gicl_command_link gicl_command_link_sva chk_u (.clk_sys_in, .resetn_in, .rx_in, .tx_out, .busy_out,
   .rx_overrun_out, .req_enable_out, .key_enable_out, .perm_enable_out);

/* File: dv/gicl_host_model.sv */
// Host serial model: sends command lines, collects answer characters.
`timescale 1ns/1ns
module gicl_host_model import gicl_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic tx_out,
   output logic rx_in
);
   logic [7:0] got[$]; // Characters heard from the device, oldest first.
   logic [7:0] c;
   initial rx_in = TX_IDLE_LEVEL;
   // Each character goes as start, eight bits LSB first, one stop bit.
   task automatic send_str(input string s);
      logic [9:0] f;
      for (int i = 0; i < s.len(); i++) begin
         f = {1'b1, s[i], 1'b0};
         for (int b = 0; b < 10; b++) begin
            @(negedge clk_sys_in) rx_in = f[b];
            repeat (BIT_CYCLES - 1) @(negedge clk_sys_in);
         end
      end
   endtask
   // Mid-bit sampling; a bad stop bit stores the inverse so it can never match.
   always begin
      @(negedge tx_out);
      repeat (BIT_CYCLES / 2) @(posedge clk_sys_in);
      for (int b = 0; b < 8; b++) begin
         repeat (BIT_CYCLES) @(posedge clk_sys_in);
         c[b] = tx_out;
      end
      repeat (BIT_CYCLES) @(posedge clk_sys_in);
      got.push_back(tx_out ? c : ~c);
   end
endmodule // gicl_host_model

/* File: dv/gicl_command_link_bench.sv */
// Self-checking bench for the command link.
`timescale 1ns/1ns
module gicl_command_link_bench import gicl_pkg::*; ;
   logic clk_sys_in, resetn_in, rx_in, tx_out, busy_out, rx_overrun_out;
   logic [1:0] req_enable_out, key_enable_out, perm_enable_out;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   localparam int CEIL = 98000; // One six character line plus its answers needs about 93000.
   // Gauge inputs stay quiet: a full data string would not fit in the cycle budget.
   gicl_command_link dut_u (.clk_sys_in, .resetn_in, .rx_in, .meas_neg_in(2'h0), .meas_bcd_in(56'h0),
      .meas_point_in(6'h0), .meas_key_in(2'h0), .tx_out, .busy_out, .rx_overrun_out,
      .req_enable_out, .key_enable_out, .perm_enable_out);
   gicl_host_model host_u (.clk_sys_in, .tx_out, .rx_in);
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Idle line and enable defaults once reset lifts.
   task automatic t_reset_state;
      check({7'h0, tx_out}, {7'h0, TX_IDLE_LEVEL});
      check({6'h0, req_enable_out}, {6'h0, REQ_EN_RESET});
      check({6'h0, key_enable_out}, {6'h0, KEY_EN_RESET});
      check({6'h0, perm_enable_out}, {6'h0, PERM_EN_RESET});
   endtask
   // Undefined then valid command on one line: one answer each, in line order.
   // The valid one disables requests, so req_enable_out must read zero once its answer is heard.
   task automatic t_two_cmds;
      logic [7:0] exp[6];
      exp = '{LET_E, syntax_error_code, CR, LET_O, LET_K, CR};
      host_u.send_str("X:DAD\r");
      for (int i = 0; i < 40000 && host_u.got.size() < 6; i++) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check(8'(host_u.got.size()), 8'h06);
      for (int i = 0; i < 6; i++) check(host_u.got[i], exp[i]);
      check({7'h0, rx_overrun_out}, 8'h00);
      check({6'h0, req_enable_out}, 8'h00);
   endtask
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      resetn_in = 1'b0;
      repeat (12) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      @(negedge clk_sys_in);
      t_reset_state;
      t_two_cmds;
      test_done;
   end
endmodule // gicl_command_link_bench
